// ==== scan_chain_pkg.sv ====
package scan_chain_pkg;

  // Chain geometry
  localparam int SLOTS = 2;
  localparam int SLOT_BITS = 8;
  localparam int FRAME_BITS = 16;
  localparam int SYNC_W = 28;

  // Register offsets on the software port
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0c;

  // Event bits in status and mask
  localparam int NUM_EV = 6;
  localparam int EV_FRAME = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_BUTTON = 4;

  // Values after reset
  localparam logic [NUM_EV-1:0] STATUS_RESET = 6'h00;
  localparam logic [NUM_EV-1:0] MASK_RESET = 6'h00;
  localparam logic CONTROL_RESET = 1'h1;

  // Input channel addresses
  localparam logic [1:0] CH_IRQ_INPUTS = 2'h0;
  localparam logic [1:0] CH_PLAIN_INPUTS = 2'h1;
  localparam logic [1:0] CH_DIAG_ONE = 2'h2;
  localparam logic [1:0] CH_DIAG_TWO = 2'h3;

  // Field positions within an output control byte
  localparam int OB_PWR = 0;
  localparam int OB_CLK = 1;
  localparam int OB_BUS = 2;
  localparam int OB_RST = 3;
  localparam int OB_PLED = 4;
  localparam int OB_ALED = 5;

  // Slot output state at supply-good rise and at reset
  localparam logic INIT_PWR = 1'h0;
  localparam logic INIT_CLK = 1'h1;
  localparam logic INIT_BUS = 1'h1;
  localparam logic INIT_RST = 1'h0;
  localparam logic INIT_PLED = 1'h1;
  localparam logic INIT_ALED = 1'h1;

  typedef enum logic [1:0] {SEL_IDLE, SEL_LSB, SEL_MSB, SEL_RSV} sel_state_t;

endpackage

// ==== pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
  import scan_chain_pkg::*;
#(
  parameter int W = SYNC_W
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Pins in and synchronised copy out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= '0;
      q <= '0;
    end
    else if (clk_en)
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // pin_sync

// ==== hotplug_scan_chain.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Two-bit channel picks interrupt, plain, diagnostic one or diagnostic two
// - Input chain data passes through a shift register to input chain out
// - Channel 00 bytes carry switch, button, fault and both presence bits
// - After own sixteen bits, downstream bits follow; six slots make 48
// - Channel 01 bytes carry 66 MHz, mode capability bits and aux fault
// - Channel 10 bits 0 and 8 read one: controller present
// - Channel 10 bits 1-6 read back power, clock, bus, reset, indicators
// - Channel 11 bits 0,1 and 8,9 give straps caught at supply rise
// - Control bytes arrive farthest slot first, slot A last
// - After a full shift this device holds slot A and B bytes
// - Control byte: power, clock, bus, reset low-active, two indicators
// - Older control bytes move on through output chain out
// - One strobe latches power, enables, indicators; another latches reset
// - Slot fault forces reset and drops clock and bus enables
// - Supply-good rise sets indicators and enables high, reset low
module hotplug_scan_chain
  import scan_chain_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Input scan chain
  input wire logic input_shift_clock,
  input wire logic channel_select_line,
  input wire logic input_chain_in,
  output logic input_chain_out,
  // Output control chain
  input wire logic output_shift_clock,
  input wire logic output_chain_in,
  output logic output_chain_out,
  input wire logic control_latch_strobe,
  input wire logic slot_reset_latch_strobe,
  // Supply and straps
  input wire logic supply_good,
  input wire logic [1:0] mode_strap,
  // Slot inputs, bit 0 slot A, bit 1 slot B
  input wire logic [SLOTS-1:0] interlock_switch,
  input wire logic [SLOTS-1:0] attention_button,
  input wire logic [SLOTS-1:0] presence_bit_one,
  input wire logic [SLOTS-1:0] presence_bit_two,
  input wire logic [SLOTS-1:0] freq66_capable,
  input wire logic [SLOTS-1:0] mode_cap_low,
  input wire logic [SLOTS-1:0] mode_cap_high,
  input wire logic [SLOTS-1:0] main_power_fault,
  input wire logic [SLOTS-1:0] aux_power_fault,
  // Slot outputs
  output logic [SLOTS-1:0] power_request,
  output logic [SLOTS-1:0] slot_clock_enable,
  output logic [SLOTS-1:0] slot_bus_enable,
  output logic [SLOTS-1:0] slot_reset_out,
  output logic [SLOTS-1:0] power_indicator,
  output logic [SLOTS-1:0] attention_indicator,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  typedef struct packed {
    sel_state_t sel;
    logic [1:0] chan;
    logic [FRAME_BITS-1:0] in_sr;
    logic [FRAME_BITS-1:0] out_sr;
    logic in_clk_prev;
    logic out_clk_prev;
    logic ctl_prev;
    logic rst_prev;
    logic pg_prev;
    logic [SLOTS-1:0] fault_prev;
    logic [SLOTS-1:0] button_prev;
    logic [SLOTS-1:0] pwr_req;
    logic [SLOTS-1:0] clk_q;
    logic [SLOTS-1:0] bus_q;
    logic [SLOTS-1:0] rst_q;
    logic [SLOTS-1:0] pled_q;
    logic [SLOTS-1:0] aled_q;
    logic [SLOTS-1:0] clk_pin;
    logic [SLOTS-1:0] bus_pin;
    logic [SLOTS-1:0] rst_pin;
    logic [1:0] strap;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    logic ctrl_en;
    logic irq;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic [SYNC_W-1:0] s;
  logic s_sck, s_sel, s_icin, s_ock, s_ocin, s_ctl, s_rstl, s_pg;
  logic [1:0] s_strap;
  logic [SLOTS-1:0] s_sw, s_btn, s_p1, s_p2, s_f66, s_capl, s_caph;
  logic [SLOTS-1:0] s_mflt, s_aflt, fault;
  logic [SLOT_BITS-1:0] ch0_byte [SLOTS];
  logic [SLOT_BITS-1:0] ch1_byte [SLOTS];
  logic [SLOT_BITS-1:0] ch2_byte [SLOTS];
  logic [SLOT_BITS-1:0] ch3_byte [SLOTS];
  logic [FRAME_BITS-1:0] load_word;
  logic in_rise, out_rise, ctl_rise, rstl_rise, pg_rise;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] clr;

  // Every chain, strobe, supply, strap and slot pin, link clocks included, is sampled twice before use; the register port is not
  pin_sync #(.W(SYNC_W)) u_sync
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .d({aux_power_fault, main_power_fault, mode_cap_high, mode_cap_low,
        freq66_capable, presence_bit_two, presence_bit_one,
        attention_button, interlock_switch, mode_strap, supply_good,
        slot_reset_latch_strobe, control_latch_strobe, output_chain_in,
        output_shift_clock, input_chain_in, channel_select_line,
        input_shift_clock}),
    .q(s)
  );

  assign {s_aflt, s_mflt, s_caph, s_capl, s_f66, s_p2, s_p1, s_btn, s_sw,
          s_strap, s_pg, s_rstl, s_ctl, s_ocin, s_ock, s_icin, s_sel,
          s_sck} = s;

  assign in_rise = s_sck & ~st.in_clk_prev;
  assign out_rise = s_ock & ~st.out_clk_prev;
  assign ctl_rise = s_ctl & ~st.ctl_prev;
  assign rstl_rise = s_rstl & ~st.rst_prev;
  assign pg_rise = s_pg & ~st.pg_prev;

  // Per-slot status bytes; slot A fills bits 0-7, slot B bits 8-15
  for (genvar g = 0; g < SLOTS; g++)
  begin : g_slot
    assign fault[g] = s_mflt[g] | s_aflt[g];
    assign ch0_byte[g] = {3'h0, s_p1[g], s_p2[g], fault[g], s_btn[g],
                          s_sw[g]};
    assign ch1_byte[g] = {4'h0, s_aflt[g], s_caph[g], s_capl[g],
                          s_f66[g]};
    assign ch2_byte[g] = {1'h0, st.aled_q[g], st.pled_q[g], st.rst_pin[g],
                          ~st.bus_pin[g], ~st.clk_pin[g], st.pwr_req[g],
                          1'h1};
    assign ch3_byte[g] = {5'h0, 1'h1, st.strap[1],
                          st.strap[0]};
  end

  always_comb
  begin
    case (st.chan)
      CH_IRQ_INPUTS: load_word = {ch0_byte[1], ch0_byte[0]};
      CH_PLAIN_INPUTS: load_word = {ch1_byte[1], ch1_byte[0]};
      CH_DIAG_ONE: load_word = {ch2_byte[1], ch2_byte[0]};
      CH_DIAG_TWO: load_word = {ch3_byte[1], ch3_byte[0]};
      default: load_word = '0;
    endcase
  end

  always_comb
  begin
    next_st = st;
    ev = '0;
    clr = '0;
    next_st.in_clk_prev = s_sck;
    next_st.out_clk_prev = s_ock;
    next_st.ctl_prev = s_ctl;
    next_st.rst_prev = s_rstl;
    next_st.pg_prev = s_pg;
    next_st.fault_prev = fault;
    next_st.button_prev = s_btn;

    // Channel select runs alongside shifting; the word loads on the
    // reserved-bit edge so the first own bit shows right after it
    if (in_rise)
    begin
      case (st.sel)
        SEL_IDLE:
        begin
          if (!s_sel)
            next_st.sel = SEL_LSB;
        end
        SEL_LSB:
        begin
          next_st.chan[0] = s_sel;
          next_st.sel = SEL_MSB;
        end
        SEL_MSB:
        begin
          next_st.chan[1] = s_sel;
          next_st.sel = SEL_RSV;
        end
        SEL_RSV:
        begin
          next_st.sel = SEL_IDLE;
        end
        default:
        begin
          next_st.sel = SEL_IDLE;
        end
      endcase
      if (st.sel == SEL_RSV)
      begin
        next_st.in_sr = load_word;
        ev[EV_FRAME] = 1'b1;
      end
      else
        next_st.in_sr = {s_icin, st.in_sr[FRAME_BITS-1:1]};
    end

    // Last byte in is slot A, so it ends in the upper half
    if (out_rise)
      next_st.out_sr = {s_ocin, st.out_sr[FRAME_BITS-1:1]};

    for (int i = 0; i < SLOTS; i++)
    begin
      if (ctl_rise)
      begin
        next_st.pwr_req[i] = st.out_sr[(SLOTS-1-i)*SLOT_BITS+OB_PWR];
        next_st.clk_q[i] = st.out_sr[(SLOTS-1-i)*SLOT_BITS+OB_CLK];
        next_st.bus_q[i] = st.out_sr[(SLOTS-1-i)*SLOT_BITS+OB_BUS];
        next_st.pled_q[i] = st.out_sr[(SLOTS-1-i)*SLOT_BITS+OB_PLED];
        next_st.aled_q[i] = st.out_sr[(SLOTS-1-i)*SLOT_BITS+OB_ALED];
      end
      if (rstl_rise)
        next_st.rst_q[i] = st.out_sr[(SLOTS-1-i)*SLOT_BITS+OB_RST];
    end

    // Supply rise beats any strobe in the same cycle
    if (pg_rise)
    begin
      next_st.pwr_req = {SLOTS{INIT_PWR}};
      next_st.clk_q = {SLOTS{INIT_CLK}};
      next_st.bus_q = {SLOTS{INIT_BUS}};
      next_st.rst_q = {SLOTS{INIT_RST}};
      next_st.pled_q = {SLOTS{INIT_PLED}};
      next_st.aled_q = {SLOTS{INIT_ALED}};
      next_st.strap = s_strap;
    end

    // Fault override costs one sys_clk after the synchroniser
    next_st.clk_pin = next_st.clk_q & ~fault;
    next_st.bus_pin = next_st.bus_q & ~fault;
    next_st.rst_pin = next_st.rst_q & ~fault;

    ev[EV_LATCH] = ctl_rise | rstl_rise;
    ev[EV_FAULT +: SLOTS] = fault & ~st.fault_prev;
    ev[EV_BUTTON +: SLOTS] = s_btn & ~st.button_prev;

    if (reg_wr)
    begin
      case (reg_addr)
        OFF_STATUS: clr = reg_wdata[NUM_EV-1:0];
        OFF_MASK: next_st.mask = reg_wdata[NUM_EV-1:0];
        OFF_CONTROL: next_st.ctrl_en = reg_wdata[0];
        default: clr = '0;
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq = next_st.ctrl_en & (|(next_st.status & next_st.mask));

    next_st.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_STATUS: next_st.rdata = {26'h0, st.status};
        OFF_MASK: next_st.rdata = {26'h0, st.mask};
        OFF_CONTROL: next_st.rdata = {31'h0, st.ctrl_en};
        OFF_STATE: next_st.rdata = {16'h0, st.chan, st.strap, st.aled_q,
                                    st.pled_q, st.rst_pin, st.bus_pin,
                                    st.clk_pin, st.pwr_req};
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.sel <= SEL_IDLE;
      st.pwr_req <= {SLOTS{INIT_PWR}};
      st.clk_q <= {SLOTS{INIT_CLK}};
      st.bus_q <= {SLOTS{INIT_BUS}};
      st.rst_q <= {SLOTS{INIT_RST}};
      st.pled_q <= {SLOTS{INIT_PLED}};
      st.aled_q <= {SLOTS{INIT_ALED}};
      st.clk_pin <= {SLOTS{INIT_CLK}};
      st.bus_pin <= {SLOTS{INIT_BUS}};
      st.rst_pin <= {SLOTS{INIT_RST}};
      st.status <= STATUS_RESET;
      st.mask <= MASK_RESET;
      st.ctrl_en <= CONTROL_RESET;
    end
    else if (clk_en)
      st <= next_st;
  end

  assign input_chain_out = st.in_sr[0];
  assign output_chain_out = st.out_sr[0];
  assign power_request = st.pwr_req;
  assign slot_clock_enable = st.clk_pin;
  assign slot_bus_enable = st.bus_pin;
  assign slot_reset_out = st.rst_pin;
  assign power_indicator = st.pled_q;
  assign attention_indicator = st.aled_q;
  assign reg_rdata = st.rdata;
  assign irq = st.irq;

  a_fault_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && fault[0] |=> slot_reset_out[0] == 1'b0)
    else $error("slot A reset not forced by fault");

  a_fault_enables: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && fault[1] |=> !slot_clock_enable[1] && !slot_bus_enable[1])
    else $error("slot B enables not dropped by fault");

  a_present_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && in_rise && st.sel == SEL_RSV && st.chan == CH_DIAG_ONE
    |=> input_chain_out && st.in_sr[8])
    else $error("present bits missing in diagnostic one");

  a_strap_ones: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && in_rise && st.sel == SEL_RSV && st.chan == CH_DIAG_TWO
    |=> st.in_sr[2] && st.in_sr[10])
    else $error("fixed ones missing in diagnostic two");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && in_rise && st.sel == SEL_RSV && st.chan == CH_IRQ_INPUTS
    |=> st.in_sr[7:5] == 3'h0 && st.in_sr[15:13] == 3'h0)
    else $error("reserved input bits not zero");

  a_select_walk: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && in_rise && st.sel == SEL_IDLE && !s_sel
    |=> st.sel == SEL_LSB)
    else $error("start bit not taken");

  a_ctrl_latch: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && ctl_rise && !pg_rise
    |=> power_indicator[0] == $past(st.out_sr[8+OB_PLED])
        && attention_indicator[1] == $past(st.out_sr[OB_ALED]))
    else $error("control strobe did not load indicators");

  a_reset_latch: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && rstl_rise && !pg_rise && !fault[1]
    |=> slot_reset_out[1] == $past(st.out_sr[OB_RST]))
    else $error("reset strobe did not load slot B reset");

  a_supply_init: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && pg_rise && fault == 2'h0
    |=> power_indicator == 2'h3 && slot_bus_enable == 2'h3
        && slot_reset_out == 2'h0)
    else $error("supply rise did not initialise slots");

  a_chain_onward: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && out_rise |=> output_chain_out == $past(st.out_sr[1]))
    else $error("output chain did not move on");

endmodule // hotplug_scan_chain

// ==== hotplug_ctrl_model.sv ====
`timescale 1ns/1ps
module hotplug_ctrl_model (
  // Input chain
  output logic input_shift_clock,
  output logic channel_select_line,
  output logic input_chain_in,
  input wire logic input_chain_out,
  // Output chain and strobes
  output logic output_shift_clock,
  output logic output_chain_in,
  input wire logic output_chain_out,
  output logic control_latch_strobe,
  output logic slot_reset_latch_strobe
);
  initial
  begin
    input_shift_clock = 1'h0;
    channel_select_line = 1'h1;
    input_chain_in = 1'h0;
    output_shift_clock = 1'h0;
    output_chain_in = 1'h0;
    control_latch_strobe = 1'h0;
    slot_reset_latch_strobe = 1'h0;
  end

  // Link clock stands low between frames; 32 ns period inside a frame
  task automatic read_channel(input logic [1:0] ch,
    input logic [15:0] down, output logic [31:0] got);
    logic [3:0] sel;
    sel = {1'h1, ch, 1'h0};
    #3;
    for (int i = 0; i < 35; i++)
    begin
      channel_select_line = (i < 4) ? sel[i] : 1'h1;
      if (i >= 4 && i < 20)
        input_chain_in = down[i-4];
      #2 input_shift_clock = 1'h1;
      #16 input_shift_clock = 1'h0;
      #14;
      if (i >= 3)
        got[i-3] = input_chain_out;
    end
    // Released line must not keep showing the last bit
    input_chain_in = ~input_chain_in;
  endtask

  // Whole frame, farthest slot byte first, bit 0 first
  task automatic send_control(input logic [31:0] bits,
    output logic [31:0] seen);
    #5;
    for (int i = 0; i < 32; i++)
    begin
      output_chain_in = bits[i];
      #2 output_shift_clock = 1'h1;
      #16 output_shift_clock = 1'h0;
      #14 seen[i] = output_chain_out;
    end
    output_chain_in = ~output_chain_in;
  endtask

  task automatic latch(input logic rst_only);
    if (rst_only)
      slot_reset_latch_strobe = 1'h1;
    else
      control_latch_strobe = 1'h1;
    #32;
    slot_reset_latch_strobe = 1'h0;
    control_latch_strobe = 1'h0;
    #32;
  endtask
endmodule // hotplug_ctrl_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import scan_chain_pkg::*;
  logic sys_clk, rst_b, supply_good, reg_wr, reg_rd, irq;
  logic [1:0] mode_strap, sw, btn, p1, p2, f66, cl, ch, mf, af;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, got;
  wire isc, csl, ici, ico, osc, oci, oco, cls, rls;
  logic [1:0] pr, ce, be, ro, pl, al;
  int fails, total_checks;
  wire [11:0] outs = {pr, ce, be, ro, pl, al};

  initial
  begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  hotplug_ctrl_model ctrl (.input_shift_clock(isc),
    .channel_select_line(csl), .input_chain_in(ici),
    .input_chain_out(ico), .output_shift_clock(osc),
    .output_chain_in(oci), .output_chain_out(oco),
    .control_latch_strobe(cls), .slot_reset_latch_strobe(rls));

  hotplug_scan_chain dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_en(1'h1), .input_shift_clock(isc), .channel_select_line(csl),
    .input_chain_in(ici), .input_chain_out(ico),
    .output_shift_clock(osc), .output_chain_in(oci),
    .output_chain_out(oco), .control_latch_strobe(cls),
    .slot_reset_latch_strobe(rls), .supply_good(supply_good),
    .mode_strap(mode_strap), .interlock_switch(sw),
    .attention_button(btn), .presence_bit_one(p1),
    .presence_bit_two(p2), .freq66_capable(f66), .mode_cap_low(cl),
    .mode_cap_high(ch), .main_power_fault(mf), .aux_power_fault(af),
    .power_request(pr), .slot_clock_enable(ce), .slot_bus_enable(be),
    .slot_reset_out(ro), .power_indicator(pl),
    .attention_indicator(al), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask

  task automatic close_out();
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard: a stuck run counts against the verdict
  initial
  begin
    #100000;
    fails++;
    close_out();
  end

  initial
  begin
    {rst_b, supply_good, reg_wr, reg_rd} = 4'h0;
    {sw, btn, p1, p2, f66, cl, ch, mf, af} = 18'h0;
    mode_strap = 2'h1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    check("outs_reset", outs, 12'h3cf);
    reg_read(OFF_STATUS, got);
    check("status", got, 32'h0);
    reg_read(OFF_CONTROL, got);
    check("control", got, 32'h1);
    reg_read(8'h10, got);
    check("unmapped", got, 32'h0);
    supply_good <= 1'h1;
    repeat (4) @(posedge sys_clk);
    ctrl.read_channel(CH_DIAG_TWO, 16'ha5c3, got);
    check("ch11", got, 32'ha5c30505);
    // Aux fault on slot B only: main and aux are ORed for the fault bit
    {sw, btn, p1, p2} <= 8'h67;
    {f66, cl, ch, af} <= 8'h7a;
    repeat (4) @(posedge sys_clk);
    ctrl.read_channel(CH_IRQ_INPUTS, 16'h0ff0, got);
    check("ch00", got, 32'h0ff00e19);
    ctrl.read_channel(CH_PLAIN_INPUTS, 16'h8001, got);
    check("ch01", got, 32'h80010e03);
    check("outs_fault", outs, 12'h14f);
    reg_read(OFF_STATUS, got);
    check("status_ev", got & 32'h3c, 32'h28);
    check("irq_masked", irq, 1'h0);
    reg_write(OFF_MASK, 32'h8);
    repeat (2) @(posedge sys_clk);
    check("irq_on", irq, 1'h1);
    reg_write(OFF_STATUS, 32'h8);
    repeat (2) @(posedge sys_clk);
    check("irq_off", irq, 1'h0);
    {btn, af} <= 4'h0;
    repeat (6) @(posedge sys_clk);
    // Start from a clean status so only the latch event shows later
    reg_write(OFF_STATUS, 32'h3f);
    // Reserved bits 7:6 of slot A set on purpose; they must do nothing
    ctrl.send_control({8'hef, 8'h1c, 8'hc3, 8'h5a}, got);
    check("pass_on", got[30:15], 16'hc35a);
    check("outs_unlatched", outs, 12'h3cf);
    ctrl.latch(1'h0);
    check("outs_ctl", outs, 12'h5c9);
    ctrl.latch(1'h1);
    check("outs_rst", outs, 12'h5f9);
    reg_read(OFF_STATUS, got);
    check("status_latch", got, 32'h2);
    ctrl.read_channel(CH_DIAG_ONE, 16'h0, got);
    check("ch10", got, 32'h3553);
    reg_read(OFF_STATE, got);
    check("state", got, 32'h96f5);
    supply_good <= 1'h0;
    mode_strap <= 2'h3;
    repeat (4) @(posedge sys_clk);
    supply_good <= 1'h1;
    repeat (6) @(posedge sys_clk);
    check("outs_init", outs, 12'h3cf);
    ctrl.read_channel(CH_DIAG_TWO, 16'h0, got);
    check("ch11_new", got, 32'h0707);
    close_out();
  end
endmodule // testbench
